// file: pkg/tpwm_regs.svh
`ifndef TPWM_REGS_SVH
`define TPWM_REGS_SVH
// Function
// - Carrier period is two times (half-period setting plus one) count-source cycles.
// - Phase pulse lasts twice its nonzero 16-bit width value in count-source cycles.
// - Reference cycle is two carrier half-periods, one full carrier period.
// - Carrier reload on every underflow or only on odd-numbered underflows.
// - First start trigger counts secondary width, then widths alternate primary/secondary.
// - Width rewrites while running take effect from the next carrier cycle.
// - Two-bit select picks underflow, flag rise or flag fall as decimation event.
// - Interrupt request raised on every nth selected event, n from four-bit field.
// - Half flag is zero while first phase timer stops, toggles per start trigger.
// - Flag one means first half counting secondary; zero means last half, primary.
// - Transfer loads both level buffers; first drives, swap at each one-shot fall.
// - With dead time on, active-to-inactive is immediate, inactive-to-active waits.
// - Transfer on buffers-written underflow, carrier write when selected, or soft bit.
// - Level buffers hold six bits; dead-time setting holds eight bits.
// - Dead-time trigger, clock, active level, overlap check settings plus overlap flag.

// Register byte offsets
`define TPWM_A_CTL0   8'h00
`define TPWM_A_CTL1   8'h04
`define TPWM_A_DTS    8'h08
`define TPWM_A_CSC    8'h0C
`define TPWM_A_DEC    8'h10
`define TPWM_A_LBF    8'h14
`define TPWM_A_LBS    8'h18
`define TPWM_A_CHP    8'h1C
`define TPWM_A_WPRI   8'h20
`define TPWM_A_WSEC   8'h2C
`define TPWM_A_TSB    8'h38
`define TPWM_A_PFS    8'h3C
`define TPWM_A_PFP    8'h40
`define TPWM_A_STEP   8'h04
// motor_control_0 bits
`define TPWM_C0_ISLO  0
`define TPWM_C0_ISHI  1
`define TPWM_C0_FUSE  2
`define TPWM_C0_OEN   3
`define TPWM_C0_OVEN  4
`define TPWM_C0_OVF   5
`define TPWM_C0_MODT  6
`define TPWM_C0_SOFT  7
// motor_control_1 bits
`define TPWM_C1_STSEL 0
`define TPWM_C1_MODE1 1
`define TPWM_C1_DTCLK 2
`define TPWM_C1_HALF  3
`define TPWM_C1_ACT   4
`define TPWM_C1_DTDIS 5
`define TPWM_C1_DTTRG 6
// Other fields
`define TPWM_CSC_REL  0
`define TPWM_TSB_CAR  3
`define TPWM_FIRST_PH 1
`define TPWM_RST8     8'h00
`define TPWM_RST16    16'h0000
`endif

// file: pkg/tpwm_pkg.sv
package tpwm_pkg;
    // One-shot phase timer states
    typedef enum logic [1:0] {
        PH_IDLE = 2'b01,
        PH_RUN  = 2'b10
    } tpwm_ph_e;
    // Decimation event codes
    typedef enum logic [1:0] {
        EV_UFL  = 2'b00,
        EV_RISE = 2'b01,
        EV_FALL = 2'b10,
        EV_ALT  = 2'b11
    } tpwm_ev_e;
    typedef logic [15:0] tpwm_w_t;
endpackage

// file: verilog/tpwm_mode1.sv
`timescale 1ns/100ps
`default_nettype none
`include "tpwm_regs.svh"
module tpwm_mode1
    import tpwm_pkg::*;
#(
    parameter int CS_DIV = 1
)(
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        arst_n,
    // Avalon-MM slave
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output var  logic [31:0] avs_readdata,
    output var  logic        avs_waitrequest,
    // Power stage
    output var  logic [5:0]  pwm_pin,
    output var  logic [5:0]  pin_is_pwm,
    output var  logic        carrier_irq
);

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    // Register storage
    logic [7:0]  motor_control_0;
    logic [7:0]  motor_control_1;
    logic [7:0]  dead_time_setting;
    logic [7:0]  carrier_special_control;
    logic [3:0]  irq_decimation_count;
    logic [5:0]  level_buffer_first;
    logic [5:0]  level_buffer_second;
    tpwm_w_t     carrier_half_period;
    tpwm_w_t     phase_width_primary [3];
    tpwm_w_t     phase_width_secondary [3];
    logic [3:0]  timer_start_bits;
    logic [5:0]  pin_function_select;
    logic        pin_function_protect;
    logic        overlap_detect_flag;
    logic        carrier_half_flag;
    // Core state
    logic [15:0] cs_cnt;
    logic        cs_en;
    tpwm_w_t     cr_cnt;
    tpwm_w_t     cr_hold;
    logic        half_d;
    logic [3:0]  dec_cnt;
    logic        buf1_wr;
    logic        buf2_wr;
    logic [5:0]  sr_first;
    logic [5:0]  sr_second;
    logic [5:0]  ph_lvl;
    logic [2:0]  ovl;
    logic [31:0] next_rdata;

    // Address match on a completing write
    function automatic logic wr_hit(input logic w, input logic [7:0] a, input logic [7:0] off);
        return w && (a == off);
    endfunction

    // Bus decode
    wire       wr_acc     = avs_write & ~avs_waitrequest;
    wire       rd_start   = (avs_read | avs_write) & avs_waitrequest;
    wire       wr_c0      = wr_hit(wr_acc, avs_address, `TPWM_A_CTL0);
    wire       wr_chp     = wr_hit(wr_acc, avs_address, `TPWM_A_CHP);
    wire       wr_lbf     = wr_hit(wr_acc, avs_address, `TPWM_A_LBF);
    wire       wr_lbs     = wr_hit(wr_acc, avs_address, `TPWM_A_LBS);
    wire [7:0] wd8        = avs_writedata[7:0];

    // Mode gating
    // mode and function gate
    wire run      = motor_control_0[`TPWM_C0_FUSE] & motor_control_1[`TPWM_C1_MODE1]
                  & ~motor_control_0[`TPWM_C0_MODT];
    wire car_on   = run & timer_start_bits[`TPWM_TSB_CAR];
    wire uflow    = car_on & cs_en & (cr_cnt == `TPWM_RST16);
    wire first_on = run & timer_start_bits[`TPWM_FIRST_PH];
    wire start_tr = uflow & first_on;
    wire rel_now  = ~carrier_special_control[`TPWM_CSC_REL] | ~carrier_half_flag;
    wire half_ris = carrier_half_flag & ~half_d;
    wire half_fal = ~carrier_half_flag & half_d;
    wire [1:0] ev_sel = {motor_control_0[`TPWM_C0_ISHI], motor_control_0[`TPWM_C0_ISLO]};
    wire irq_ev   = (ev_sel == EV_RISE) ? half_ris :
                    (ev_sel == EV_FALL) ? half_fal : uflow;
    wire xfer     = (uflow & buf1_wr & buf2_wr)
                  | (wr_chp & motor_control_1[`TPWM_C1_STSEL])
                  | (wr_c0 & wd8[`TPWM_C0_SOFT]);
    wire dt_tick  = motor_control_1[`TPWM_C1_DTCLK] ? cs_en : 1'b1;
    wire dt_dis   = motor_control_1[`TPWM_C1_DTDIS];

    // Read selection
    // soft bit reads zero
    assign next_rdata =
        (avs_address == `TPWM_A_CTL0) ? {24'h00_0000, 1'b0, motor_control_0[6],
                                         overlap_detect_flag, motor_control_0[4:0]} :
        (avs_address == `TPWM_A_CTL1) ? {24'h00_0000, motor_control_1[7:4],
                                         carrier_half_flag, motor_control_1[2:0]} :
        (avs_address == `TPWM_A_DTS)  ? {24'h00_0000, dead_time_setting} :
        (avs_address == `TPWM_A_CSC)  ? {24'h00_0000, carrier_special_control} :
        (avs_address == `TPWM_A_DEC)  ? {28'h000_0000, irq_decimation_count} :
        (avs_address == `TPWM_A_LBF)  ? {26'h000_0000, level_buffer_first} :
        (avs_address == `TPWM_A_LBS)  ? {26'h000_0000, level_buffer_second} :
        (avs_address == `TPWM_A_CHP)  ? {16'h0000, carrier_half_period} :
        (avs_address == `TPWM_A_WPRI) ? {16'h0000, phase_width_primary[0]} :
        (avs_address == `TPWM_A_WPRI + `TPWM_A_STEP) ? {16'h0000, phase_width_primary[1]} :
        (avs_address == `TPWM_A_WPRI + 2*`TPWM_A_STEP) ? {16'h0000, phase_width_primary[2]} :
        (avs_address == `TPWM_A_WSEC) ? {16'h0000, phase_width_secondary[0]} :
        (avs_address == `TPWM_A_WSEC + `TPWM_A_STEP) ? {16'h0000, phase_width_secondary[1]} :
        (avs_address == `TPWM_A_WSEC + 2*`TPWM_A_STEP) ? {16'h0000, phase_width_secondary[2]} :
        (avs_address == `TPWM_A_TSB)  ? {28'h000_0000, timer_start_bits} :
        (avs_address == `TPWM_A_PFS)  ? {26'h000_0000, pin_function_select} :
        (avs_address == `TPWM_A_PFP)  ? {31'h0000_0000, pin_function_protect} :
        32'h0000_0000;

    // Bus handshake, one wait cycle
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0000_0000;
        end else begin
            avs_waitrequest <= ~rd_start;
            if (rd_start) begin
                avs_readdata <= next_rdata;
            end
        end
    end

    // Count-source divider
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            cs_cnt <= `TPWM_RST16;
            cs_en  <= 1'b0;
        end else begin
            cs_en  <= (cs_cnt == 16'(CS_DIV - 1));
            cs_cnt <= (cs_cnt == 16'(CS_DIV - 1)) ? `TPWM_RST16 : cs_cnt + 16'h0001;
        end
    end

    // Software-written registers
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            motor_control_0         <= `TPWM_RST8;
            motor_control_1         <= `TPWM_RST8;
            dead_time_setting       <= `TPWM_RST8;
            carrier_special_control <= `TPWM_RST8;
            irq_decimation_count    <= 4'h0;
            level_buffer_first      <= 6'h00;
            level_buffer_second     <= 6'h00;
            carrier_half_period     <= `TPWM_RST16;
            timer_start_bits        <= 4'h0;
            pin_function_select     <= 6'h00;
            pin_function_protect    <= 1'b0;
        end else begin
            if (wr_c0) motor_control_0 <= {1'b0, wd8[6:0]};
            if (wr_hit(wr_acc, avs_address, `TPWM_A_CTL1)) motor_control_1 <= {1'b0, wd8[6:0]};
            if (wr_hit(wr_acc, avs_address, `TPWM_A_DTS)) dead_time_setting <= wd8;
            if (wr_hit(wr_acc, avs_address, `TPWM_A_CSC)) carrier_special_control <= wd8;
            if (wr_hit(wr_acc, avs_address, `TPWM_A_DEC)) irq_decimation_count <= wd8[3:0];
            if (wr_lbf) level_buffer_first <= wd8[5:0];
            if (wr_lbs) level_buffer_second <= wd8[5:0];
            if (wr_chp) carrier_half_period <= avs_writedata[15:0];
            if (wr_hit(wr_acc, avs_address, `TPWM_A_TSB)) timer_start_bits <= wd8[3:0];
            if (wr_hit(wr_acc, avs_address, `TPWM_A_PFS) && pin_function_protect) begin
                pin_function_select <= wd8[5:0];
            end
            if (wr_hit(wr_acc, avs_address, `TPWM_A_PFP)) pin_function_protect <= wd8[0];
        end
    end

    // Carrier half-period timer
    // two halves of m+1 ticks
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            cr_cnt  <= `TPWM_RST16;
            cr_hold <= `TPWM_RST16;
        end else if (!car_on) begin
            cr_cnt  <= carrier_half_period;
            cr_hold <= carrier_half_period;
        end else if (uflow) begin
            cr_cnt  <= rel_now ? carrier_half_period : cr_hold;
            if (rel_now) cr_hold <= carrier_half_period;
        end else if (cs_en) begin
            cr_cnt  <= cr_cnt - 16'h0001;
        end
    end

    // Half flag, decimation and interrupt
    // half flag tracking
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            carrier_half_flag <= 1'b0;
            half_d            <= 1'b0;
            dec_cnt           <= 4'h0;
            carrier_irq       <= 1'b0;
        end else begin
            carrier_half_flag <= first_on & (carrier_half_flag ^ start_tr);
            half_d            <= carrier_half_flag;
            carrier_irq       <= 1'b0;
            if (irq_ev) begin
                if (dec_cnt + 4'h1 >= irq_decimation_count) begin
                    dec_cnt     <= 4'h0;
                    carrier_irq <= 1'b1;
                end else begin
                    dec_cnt <= dec_cnt + 4'h1;
                end
            end
        end
    end

    // Transfer, buffer-written flags and overlap flag
    // buffer load on transfer
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            buf1_wr             <= 1'b0;
            buf2_wr             <= 1'b0;
            sr_first            <= 6'h00;
            sr_second           <= 6'h00;
            overlap_detect_flag <= 1'b0;
        end else begin
            buf1_wr <= wr_lbf | (buf1_wr & ~xfer);
            buf2_wr <= wr_lbs | (buf2_wr & ~xfer);
            if (xfer) begin
                sr_first  <= level_buffer_first;
                sr_second <= level_buffer_second;
            end
            overlap_detect_flag <= (|ovl) |
                (overlap_detect_flag & ~(wr_c0 & ~wd8[`TPWM_C0_OVF]));
        end
    end

    // Pin stage
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            pwm_pin    <= 6'h00;
            pin_is_pwm <= 6'h00;
        end else begin
            pwm_pin    <= motor_control_1[`TPWM_C1_ACT] ?
                          (ph_lvl & {6{motor_control_0[`TPWM_C0_OEN]}}) :
                          ~(ph_lvl & {6{motor_control_0[`TPWM_C0_OEN]}});
            pin_is_pwm <= pin_function_select;
        end
    end

    // Per-phase one-shot, level select and dead time
    for (genvar i = 0; i < 3; i++) begin : g_ph
        tpwm_ph_e    st;
        logic [16:0] pcnt;
        tpwm_w_t     shp;
        logic        sel;
        logic [7:0]  dtc;
        logic [1:0]  lvl_d;
        logic [1:0]  ph;
        wire         pst   = uflow & timer_start_bits[i] & run;
        wire tpwm_w_t ld   = carrier_half_flag ? shp : phase_width_secondary[i];
        wire         fall  = (st == PH_RUN) & cs_en & (pcnt == 17'h0_0001) & ~pst;
        wire [1:0]   tgt   = sel ? {sr_second[i+3], sr_second[i]} : {sr_first[i+3], sr_first[i]};
        wire         both  = motor_control_0[`TPWM_C0_OVEN] & (&tgt);
        wire         dt_tr = motor_control_1[`TPWM_C1_DTTRG] ? fall : (tgt != lvl_d);
        wire         dt_ok = dt_dis | ((dtc == `TPWM_RST8) & ~dt_tr);
        wire [1:0]   next_ph = both ? 2'b00 : (tgt & (ph | {2{dt_ok}}));

        assign ovl[i]      = both;
        assign ph_lvl[i]   = ph[0];
        assign ph_lvl[i+3] = ph[1];

        // Width registers, primary shadow
        always_ff @(posedge core_clk or negedge arst_n) begin
            if (!arst_n) begin
                phase_width_primary[i]   <= `TPWM_RST16;
                phase_width_secondary[i] <= `TPWM_RST16;
                shp                      <= `TPWM_RST16;
            end else begin
                if (wr_hit(wr_acc, avs_address, 8'(`TPWM_A_WPRI + i*`TPWM_A_STEP))) begin
                    phase_width_primary[i] <= avs_writedata[15:0];
                end
                if (wr_hit(wr_acc, avs_address, 8'(`TPWM_A_WSEC + i*`TPWM_A_STEP))) begin
                    phase_width_secondary[i] <= avs_writedata[15:0];
                end
                if (pst && !carrier_half_flag) shp <= phase_width_primary[i];
            end
        end

        // One-shot timer
        // twice the width in ticks
        always_ff @(posedge core_clk or negedge arst_n) begin
            if (!arst_n) begin
                st   <= PH_IDLE;
                pcnt <= 17'h0_0000;
            end else if (pst && ld != `TPWM_RST16) begin
                st   <= PH_RUN;
                pcnt <= {ld, 1'b0};
            end else begin
                unique case (st)
                    PH_IDLE: pcnt <= 17'h0_0000;
                    PH_RUN: begin
                        if (cs_en) begin
                            pcnt <= pcnt - 17'h0_0001;
                            if (pcnt == 17'h0_0001) st <= PH_IDLE;
                        end
                    end
                endcase
            end
        end

        // Level select and dead time
        // swap buffer at each fall
        always_ff @(posedge core_clk or negedge arst_n) begin
            if (!arst_n) begin
                sel   <= 1'b0;
                dtc   <= `TPWM_RST8;
                lvl_d <= 2'b00;
                ph    <= 2'b00;
            end else begin
                sel   <= xfer ? 1'b0 : (sel ^ fall);
                lvl_d <= tgt;
                ph    <= next_ph;
                if (dt_tr) begin
                    dtc <= dead_time_setting;
                end else if (dt_tick && dtc != `TPWM_RST8) begin
                    dtc <= dtc - 8'h01;
                end
            end
        end

        sequence s_start;
            pst && ld != `TPWM_RST16;
        endsequence
        sequence s_first_start;
            s_start ##0 !carrier_half_flag;
        endsequence

        AST_WIDTH_LOAD: assert property (s_start |=> pcnt == {$past(ld), 1'b0})
            else $error("pulse width load is not twice the width");
        AST_SEC_FIRST: assert property (s_first_start |=>
            pcnt[16:1] == $past(phase_width_secondary[i]))
            else $error("first half did not count secondary width");
        AST_XFER_FIRST: assert property (xfer |=> !sel)
            else $error("transfer did not select first buffer");
        AST_FALL_SWAP: assert property (fall && !xfer |=> sel != $past(sel))
            else $error("buffer select did not swap on fall");
        AST_OFF_NOW: assert property (!tgt[0] |=> !ph[0])
            else $error("turn-off was delayed");
        AST_ON_WAIT: assert property ($rose(ph[0]) && !$past(dt_dis) |->
            $past(dtc) == `TPWM_RST8)
            else $error("turn-on before dead time ended");
    end

    AST_HALF_STOP: assert property (!first_on |=> !carrier_half_flag)
        else $error("half flag not held low while stopped");
    AST_HALF_TOG: assert property (start_tr ##1 first_on |->
        carrier_half_flag != $past(carrier_half_flag))
        else $error("half flag did not toggle on start trigger");
    AST_RELOAD: assert property (uflow && rel_now |=>
        cr_cnt == $past(carrier_half_period))
        else $error("carrier did not reload period");
    AST_IRQ_CAUSE: assert property (carrier_irq |-> $past(irq_ev))
        else $error("interrupt without counted event");
    AST_SOFT_ZERO: assert property ($fell(avs_waitrequest) &&
        avs_read && avs_address == `TPWM_A_CTL0 |-> !avs_readdata[`TPWM_C0_SOFT])
        else $error("soft trigger bit read back as one");
    AST_XFER_LOAD: assert property (xfer |=>
        sr_first == $past(level_buffer_first) && sr_second == $past(level_buffer_second))
        else $error("transfer did not load buffers");

endmodule
`default_nettype wire

// file: bench/tpwm_stage.sv
`timescale 1ns/100ps
`default_nettype none
module tpwm_stage (
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       arst_n,
    // Gate drive from the block
    input  wire logic [5:0] pwm_pin,
    input  wire logic [5:0] pin_is_pwm,
    // Fault count
    output var  int         shoots
);
    // Leg overlap counter, gates taken as active high
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            shoots <= 0;
        end else if (|(pwm_pin[2:0] & pwm_pin[5:3] & pin_is_pwm[2:0] & pin_is_pwm[5:3])) begin
            shoots <= shoots + 1;
        end
    end
endmodule
`default_nettype wire

// file: bench/tpwm_mode1_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "tpwm_regs.svh"
module tpwm_mode1_tb_top;
    logic        core_clk;
    logic        arst_n;
    logic        avs_read;
    logic        avs_write;
    logic [7:0]  avs_address;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [5:0]  pwm_pin;
    logic [5:0]  pin_is_pwm;
    logic        carrier_irq;
    logic [31:0] q;
    int          n_fail;
    int          tests_run;
    int          m;
    int          c;
    int          r;
    int          shoots;
    realtime     t0;

    tpwm_mode1 #(.CS_DIV(1)) tpwm_mode1_i (
        .core_clk(core_clk), .arst_n(arst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .pwm_pin(pwm_pin), .pin_is_pwm(pin_is_pwm), .carrier_irq(carrier_irq));

    tpwm_stage tpwm_stage_i (
        .core_clk(core_clk), .arst_n(arst_n), .pwm_pin(pwm_pin),
        .pin_is_pwm(pin_is_pwm), .shoots(shoots));

    // Clock
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    // Watchdog
    initial begin
        #2_000_000;
        n_fail++;
        test_done();
    end

    // Verdict and end of run
    task automatic test_done;
        $display("tests_run=%0d n_fail=%0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Compare and report
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    // One Avalon access, held until waitrequest is seen low
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge core_clk);
        avs_address   <= a;
        avs_write     <= w;
        avs_read      <= !w;
        avs_writedata <= d;
        k = 0;
        do begin
            @(posedge core_clk);
            k++;
        end while (avs_waitrequest !== 1'b0 && k < 50);
        if (k >= 50) n_fail++;
        q = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask

    // Cycles between two interrupt pulses
    task automatic gap(output int n);
        n = 0;
        while (carrier_irq !== 1'b1 && n < 4000) begin
            @(posedge core_clk);
            n++;
        end
        @(posedge core_clk);
        n = 1;
        while (carrier_irq !== 1'b1 && n < 4000) begin
            @(posedge core_clk);
            n++;
        end
    endtask

    // Cycles until the pins show a given pattern
    task automatic wait_pin(input logic [5:0] v, output int n);
        n = 0;
        while (pwm_pin !== v && n < 2000) begin
            @(posedge core_clk);
            n++;
        end
    endtask

    // Main sequence
    initial begin
        arst_n = 1'b0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 8'h00;
        avs_writedata = 32'h0000_0000;
        n_fail = 0;
        tests_run = 0;
        void'($urandom(10122));
        repeat (2) @(posedge core_clk);
        arst_n <= 1'b1;
        // Reset value, random write and read back, unmapped read
        bus(0, `TPWM_A_DTS, 0); chk(q, 32'h0000_0000);
        r = $urandom;
        bus(1, `TPWM_A_DTS, r); bus(0, `TPWM_A_DTS, 0); chk(q, {24'h0, r[7:0]});
        bus(0, 8'hFC, 0); chk(q, 32'h0000_0000);
        // Mode one, active high, no dead time, before any pin turns to PWM
        bus(1, `TPWM_A_CTL1, 32'h32);
        // Pin function write refused without protect, taken with it
        bus(1, `TPWM_A_PFS, 32'h3F); bus(0, `TPWM_A_PFS, 0); chk(q, 32'h0000_0000);
        bus(1, `TPWM_A_PFP, 1); bus(1, `TPWM_A_PFS, 32'h3F); bus(1, `TPWM_A_PFP, 0);
        chk({26'h0, pin_is_pwm}, 32'h0000_003F);
        // Level buffers, function and outputs on, soft transfer
        bus(1, `TPWM_A_LBF, 32'h07); bus(1, `TPWM_A_LBS, 32'h38);
        bus(1, `TPWM_A_CTL0, 32'h8C);
        bus(0, `TPWM_A_CTL0, 0); chk(q, 32'h0000_000C);
        chk({26'h0, pwm_pin}, 32'h0000_0007);
        bus(0, `TPWM_A_CTL1, 0); chk({31'h0, q[3]}, 32'h0000_0000);
        // Random half period, widths, start all timers
        m = $urandom_range(20, 60);
        bus(1, `TPWM_A_CHP, m);
        for (int i = 0; i < 3; i++) begin
            bus(1, `TPWM_A_WPRI + 8'(4 * i), 32'h4);
            bus(1, `TPWM_A_WSEC + 8'(4 * i), 32'h6);
        end
        bus(1, `TPWM_A_DEC, 1); bus(1, `TPWM_A_TSB, 32'hF);
        // Each decimation event: underflow, flag rise, flag fall
        for (int e = 0; e < 3; e++) begin
            bus(1, `TPWM_A_CTL0, 32'h0C | e);
            gap(c); gap(c);
            chk(c, (e == 0) ? m + 1 : 2 * (m + 1));
        end
        // Every second underflow with decimation two
        bus(1, `TPWM_A_CTL0, 32'h0C); bus(1, `TPWM_A_DEC, 2);
        gap(c); gap(c); chk(c, 2 * (m + 1));
        // Reload at odd underflows only: a first-half rewrite waits one half
        bus(1, `TPWM_A_CSC, 1);
        bus(1, `TPWM_A_DEC, 1);
        bus(1, `TPWM_A_CTL0, 32'h0D);
        gap(c);
        gap(c);
        chk(c, 2 * (m + 1));
        t0 = $realtime;
        bus(1, `TPWM_A_CHP, m + 7);
        r = 0;
        while (carrier_irq !== 1'b1 && r < 4000) begin
            @(posedge core_clk);
            r++;
        end
        c = int'(($realtime - t0) / 25.0);
        chk(c, 2 * (m + 1));
        // Dead time on: turn-on waits the load cycle plus the dead time
        r = $urandom_range(1, 12);
        bus(1, `TPWM_A_DTS, r);
        bus(1, `TPWM_A_CTL1, 32'h12);
        wait_pin(6'h07, c);
        wait_pin(6'h00, c);
        wait_pin(6'h38, c);
        chk(c, r + 1);
        // Second buffer reaches the pins after a one-shot fall
        chk({26'h0, pwm_pin}, 32'h0000_0038);
        chk(shoots, 0);
        test_done();
    end
endmodule
`default_nettype wire
